/* File: common/spw_pkg.sv */
// Package for the sleep, power reduction and wake controller
package spw_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_SLEEP_CTRL = 4'h0;
	localparam logic [3:0] ADDR_CLK_STOP   = 4'h1;
	localparam logic [3:0] ADDR_PIN_EN     = 4'h2;
	localparam logic [3:0] ADDR_PIN_SENSE  = 4'h3;
	localparam logic [3:0] ADDR_TMR_CFG    = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STAT   = 4'h5;
	localparam logic [3:0] ADDR_IRQ_MASK   = 4'h6;
	localparam logic [3:0] ADDR_STATE      = 4'h7;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int POS_SLEEP_EN   = 3;
	localparam int POS_XTAL_SEL   = 4;
	localparam int POS_TMR_RUN    = 0;
	localparam int POS_TMR_ASYNC  = 1;
	localparam int POS_TMR_SYNC   = 2;
	localparam int POS_TMR_OVF_IE = 3;
	localparam int POS_TMR_CMP_IE = 4;
	localparam int IRQ_WAKE       = 0;
	localparam int IRQ_PIN0       = 1;
	localparam int IRQ_PIN1       = 2;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int PIN_EN_BITS    = 2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int STANDBY_WAKE_CYC = 6;
	localparam int WAKE_CNT_W       = 3;

	// ----------------------------------------------------------------
	// Modes, states, carriers
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SPW_IDLE     = 3'b000,
		SPW_ADC_NR   = 3'b001,
		SPW_PDOWN    = 3'b010,
		SPW_PSAVE    = 3'b011,
		SPW_RSV4     = 3'b100,
		SPW_RSV5     = 3'b101,
		SPW_STANDBY  = 3'b110,
		SPW_RSV7     = 3'b111
	} spw_mode_t;

	typedef enum logic [1:0] {
		SPW_ST_RUN   = 2'b00,
		SPW_ST_SLEEP = 2'b01,
		SPW_ST_WAKE  = 2'b10
	} spw_state_t;

	typedef enum logic [1:0] {
		SENSE_LOW  = 2'b00,
		SENSE_ANY  = 2'b01,
		SENSE_FALL = 2'b10,
		SENSE_RISE = 2'b11
	} spw_sense_t;

	typedef struct packed {
		logic cpu;
		logic flash;
		logic io;
		logic adc;
		logic asy;
		logic main_osc;
		logic timer_osc;
	} spw_clk_t;

	typedef struct packed {
		logic two_wire_port;
		logic watchdog;
		logic pin_change;
		logic spm_ready;
		logic adc_done;
		logic other;
		logic tmr_ovf;
		logic tmr_cmp;
	} spw_wake_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} spw_bus_t;

endpackage : spw_pkg

/* File: verilog/spw_pin_sense.sv */
// Edge or level sense for one external interrupt pin
`timescale 1ns/1ps
module spw_pin_sense
	import spw_pkg::*;
(
	input  wire logic       ref_clk_i, // Clock
	input  wire logic       rst_i,     // Sync reset
	input  wire logic       pin_i,     // Pin level, clamp already applied
	input  wire logic [1:0] sense_i,   // Sense select
	output logic            req_o,     // Edge pulse or level request
	output logic            lvl_o      // Level mode active
);
	logic prev;
	logic next_prev;

	always_comb begin
		next_prev = pin_i;
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			prev <= 1'b0;
		end else begin
			prev <= next_prev;
		end
	end

	// Pin read regardless of direction, so output pins still request
	always_comb begin
		lvl_o = (sense_i == SENSE_LOW);
		case (spw_sense_t'(sense_i))
			SENSE_LOW:  req_o = ~pin_i;
			SENSE_ANY:  req_o = pin_i ^ prev;
			SENSE_FALL: req_o = prev & ~pin_i;
			SENSE_RISE: req_o = ~prev & pin_i;
			default:    req_o = 1'b0;
		endcase
	end

endmodule : spw_pin_sense

/* File: verilog/spw_ctrl.sv */
// Sleep mode, clock gating, power reduction and wake control
// Summary of operation
// - Async timer event wakes power-save when enabled
// - Power-save stops unused timer oscillator, main clock
// - Mode 110 with crystal enters standby
// - Standby wake resumes after six cycles
// - Idle and noise-reduction clock and wake sets
// - Deep modes: pin level, two-wire, watchdog wakes
// - Timer oscillator in idle only if async
// - Stop bit gates clock, blocks register access
// - Clearing stop bit resumes peripheral unchanged
// - Deep sleep clamps digital pin inputs
// - Enabled pin interrupt bypasses input clamp
// - Clamp release on high pin sets flag
// - Enable bits 1,0 gated by global enable
// - Two-bit sense field selects edge or level
// - Output-configured pin still raises requests
// - Enable bits 7..2 read zero
`timescale 1ns/1ps
module spw_ctrl
	import spw_pkg::*;
#(
	parameter int N_PERIPH = 8,
	parameter int N_PINS   = 8
) (
	input  wire logic                ref_clk_i,     // 200 MHz clock
	input  wire logic                rst_i,         // Sync reset, high
	input  wire spw_pkg::spw_bus_t   bus_i,         // Register port
	output logic [7:0]               rdata_o,       // Read data, next cycle
	input  wire logic                sleep_i,       // Sleep instruction pulse
	input  wire logic                global_ie_i,   // Core global enable
	input  wire spw_pkg::spw_wake_t  wake_i,        // Wake sources
	input  wire logic [1:0]          ext_pin_i,     // External interrupt pins
	input  wire logic [N_PINS-1:0]   port_pin_i,    // Other digital pins
	output spw_pkg::spw_clk_t        clk_en_o,      // Clock domain enables
	output logic [N_PERIPH-1:0]      periph_clk_o,  // Per-peripheral clock enable
	output logic [N_PERIPH-1:0]      periph_acc_o,  // Peripheral register access allowed
	output logic [N_PINS-1:0]        port_in_o,     // Clamped port inputs
	output logic [1:0]               pin_irq_o,     // Pin vector requests
	output logic                     irq_o          // Level interrupt
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	// Stop bits live in one byte, so at most eight peripherals
	if (N_PERIPH < 1 || N_PERIPH > 8 || N_PINS < 1) begin : g_param_check
		$error("spw_ctrl: unsupported parameters");
	end

	logic [7:0] sleep_ctrl, next_sleep_ctrl;
	logic [7:0] clk_stop, next_clk_stop;
	logic [7:0] pin_en, next_pin_en;
	logic [7:0] pin_sense, next_pin_sense;
	logic [7:0] tmr_cfg, next_tmr_cfg;
	logic [7:0] irq_stat, next_irq_stat;
	logic [7:0] irq_mask, next_irq_mask;
	logic [7:0] next_rdata;
	spw_state_t state, next_state;
	spw_mode_t  mode, next_mode;
	logic [WAKE_CNT_W-1:0] wcnt, next_wcnt;
	spw_clk_t next_clk_en;
	logic [N_PERIPH-1:0] next_periph_clk;
	logic [N_PERIPH-1:0] next_periph_acc;
	logic [N_PINS-1:0] next_port_in;
	logic [1:0] next_pin_irq;
	logic next_irq;
	logic clamp, clamp_q, next_clamp_q;
	logic [1:0] ext_eff;
	logic [1:0] ext_req;
	logic [1:0] ext_lvl;
	logic wake_ok;
	logic tmr_wake;
	spw_mode_t sel_mode;

	// ------------------------------------------------------------
	// Pin sense
	// ------------------------------------------------------------
	// Clamp bypassed on enabled pins; disabled pins see ground
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ext_eff[i] = ext_pin_i[i] & ~(clamp & ~pin_en[i]);
		end
	end

	spw_pin_sense u_sense0 (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.pin_i     (ext_eff[0]),
		.sense_i   (pin_sense[1:0]),
		.req_o     (ext_req[0]),
		.lvl_o     (ext_lvl[0])
	);

	spw_pin_sense u_sense1 (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.pin_i     (ext_eff[1]),
		.sense_i   (pin_sense[3:2]),
		.req_o     (ext_req[1]),
		.lvl_o     (ext_lvl[1])
	);

	// ------------------------------------------------------------
	// Wake qualification
	// ------------------------------------------------------------
	always_comb begin
		sel_mode = spw_mode_t'(sleep_ctrl[2:0]);
		tmr_wake = global_ie_i & tmr_cfg[POS_TMR_RUN] &
			((wake_i.tmr_ovf & tmr_cfg[POS_TMR_OVF_IE]) | (wake_i.tmr_cmp & tmr_cfg[POS_TMR_CMP_IE]));
		wake_ok = 1'b0;
		case (mode)
			SPW_IDLE: begin
				wake_ok = (|(ext_req & pin_en[1:0]) & global_ie_i) | wake_i.pin_change | wake_i.two_wire_port
					| wake_i.watchdog | wake_i.spm_ready | wake_i.adc_done | wake_i.other | tmr_wake;
			end
			SPW_ADC_NR: begin
				wake_ok = (|(ext_req & ext_lvl & pin_en[1:0]) & global_ie_i) | wake_i.pin_change
					| wake_i.two_wire_port | wake_i.watchdog | wake_i.spm_ready | wake_i.adc_done | tmr_wake;
			end
			SPW_PSAVE: begin
				wake_ok = (|(ext_req & ext_lvl & pin_en[1:0]) & global_ie_i) | wake_i.pin_change
					| wake_i.two_wire_port | wake_i.watchdog | tmr_wake;
			end
			default: begin
				wake_ok = (|(ext_req & ext_lvl & pin_en[1:0]) & global_ie_i) | wake_i.pin_change
					| wake_i.two_wire_port | wake_i.watchdog;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Sleep state machine
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_mode  = mode;
		next_wcnt  = wcnt;
		case (state)
			SPW_ST_RUN: begin
				if (sleep_i && sleep_ctrl[POS_SLEEP_EN]) begin
					next_state = SPW_ST_SLEEP;
					// Standby only with crystal, else falls back to power-down
					if (sel_mode == SPW_STANDBY && !sleep_ctrl[POS_XTAL_SEL]) begin
						next_mode = SPW_PDOWN;
					end else begin
						next_mode = sel_mode;
					end
				end
			end
			SPW_ST_SLEEP: begin
				if (wake_ok) begin
					if (mode == SPW_STANDBY) begin
						next_state = SPW_ST_WAKE;
						next_wcnt  = WAKE_CNT_W'(STANDBY_WAKE_CYC - 1);
					end else begin
						next_state = SPW_ST_RUN;
					end
				end
			end
			SPW_ST_WAKE: begin
				if (wcnt == '0) begin
					next_state = SPW_ST_RUN;
				end else begin
					next_wcnt = wcnt - 1'b1;
				end
			end
			default: next_state = SPW_ST_RUN;
		endcase
	end

	// ------------------------------------------------------------
	// Clock enables and clamp
	// ------------------------------------------------------------
	always_comb begin
		next_clk_en = '1;
		clamp = (state != SPW_ST_RUN) && (mode == SPW_PDOWN || mode == SPW_PSAVE
			|| mode == SPW_STANDBY);
		if (next_state != SPW_ST_RUN) begin
			next_clk_en.cpu   = 1'b0;
			next_clk_en.flash = 1'b0;
			case (next_mode)
				SPW_IDLE: begin
					next_clk_en.timer_osc = tmr_cfg[POS_TMR_RUN] & tmr_cfg[POS_TMR_ASYNC];
				end
				SPW_ADC_NR: begin
					next_clk_en.io        = 1'b0;
					next_clk_en.timer_osc = tmr_cfg[POS_TMR_RUN] & tmr_cfg[POS_TMR_ASYNC];
				end
				SPW_PSAVE: begin
					next_clk_en.io        = 1'b0;
					next_clk_en.adc       = 1'b0;
					next_clk_en.asy       = tmr_cfg[POS_TMR_RUN];
					next_clk_en.timer_osc = tmr_cfg[POS_TMR_RUN] & tmr_cfg[POS_TMR_ASYNC];
					next_clk_en.main_osc  = tmr_cfg[POS_TMR_RUN] & tmr_cfg[POS_TMR_SYNC];
				end
				SPW_STANDBY: begin
					next_clk_en.io        = 1'b0;
					next_clk_en.adc       = 1'b0;
					next_clk_en.asy       = 1'b0;
					next_clk_en.timer_osc = 1'b0;
				end
				default: begin
					next_clk_en = '0;
				end
			endcase
		end
		// Only meaningful in active and idle; deep modes gate io anyway
		next_periph_clk = ~clk_stop[N_PERIPH-1:0] & {N_PERIPH{next_clk_en.io}};
		// Access blocked exactly while that peripheral's stop bit is set; io gating in sleep leaves access allowed
		next_periph_acc = ~clk_stop[N_PERIPH-1:0];
		next_port_in = port_pin_i & ~{N_PINS{clamp}};
		next_clamp_q = clamp;
		next_pin_irq = ext_req & pin_en[1:0] & {2{global_ie_i}};
	end

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	always_comb begin
		next_sleep_ctrl = sleep_ctrl;
		next_clk_stop   = clk_stop;
		next_pin_en     = pin_en;
		next_pin_sense  = pin_sense;
		next_tmr_cfg    = tmr_cfg;
		next_irq_mask   = irq_mask;
		next_irq_stat   = irq_stat;
		next_rdata      = RST_BYTE;
		if (bus_i.wr) begin
			if (bus_i.addr == ADDR_SLEEP_CTRL) begin
				next_sleep_ctrl = {3'b000, bus_i.wdata[4:0]};
			end else if (bus_i.addr == ADDR_CLK_STOP) begin
				next_clk_stop = bus_i.wdata;
			end else if (bus_i.addr == ADDR_PIN_EN) begin
				next_pin_en = {6'b00_0000, bus_i.wdata[1:0]};
			end else if (bus_i.addr == ADDR_PIN_SENSE) begin
				next_pin_sense = {4'h0, bus_i.wdata[3:0]};
			end else if (bus_i.addr == ADDR_TMR_CFG) begin
				next_tmr_cfg = {3'b000, bus_i.wdata[4:0]};
			end else if (bus_i.addr == ADDR_IRQ_STAT) begin
				next_irq_stat = irq_stat & ~bus_i.wdata;
			end else if (bus_i.addr == ADDR_IRQ_MASK) begin
				next_irq_mask = {5'b0_0000, bus_i.wdata[2:0]};
			end
		end
		// Sets applied after clear so a simultaneous event is kept
		if (state == SPW_ST_SLEEP && wake_ok) begin
			next_irq_stat[IRQ_WAKE] = 1'b1;
		end
		for (int i = 0; i < 2; i++) begin
			if (ext_req[i] && !ext_lvl[i]) begin
				next_irq_stat[IRQ_PIN0 + i] = 1'b1;
			end
			if (ext_lvl[i]) begin
				next_irq_stat[IRQ_PIN0 + i] = 1'b0;
			end
		end
		if (bus_i.rd) begin
			if (bus_i.addr == ADDR_SLEEP_CTRL) begin
				next_rdata = sleep_ctrl;
			end else if (bus_i.addr == ADDR_CLK_STOP) begin
				next_rdata = clk_stop;
			end else if (bus_i.addr == ADDR_PIN_EN) begin
				next_rdata = {6'b00_0000, pin_en[1:0]};
			end else if (bus_i.addr == ADDR_PIN_SENSE) begin
				next_rdata = pin_sense;
			end else if (bus_i.addr == ADDR_TMR_CFG) begin
				next_rdata = tmr_cfg;
			end else if (bus_i.addr == ADDR_IRQ_STAT) begin
				next_rdata = irq_stat;
			end else if (bus_i.addr == ADDR_IRQ_MASK) begin
				next_rdata = irq_mask;
			end else if (bus_i.addr == ADDR_STATE) begin
				next_rdata = {1'b0, mode, 2'b00, state};
			end
		end
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sleep_ctrl   <= RST_BYTE;
			clk_stop     <= RST_BYTE;
			pin_en       <= RST_BYTE;
			pin_sense    <= RST_BYTE;
			tmr_cfg      <= RST_BYTE;
			irq_stat     <= RST_BYTE;
			irq_mask     <= RST_BYTE;
			rdata_o      <= RST_BYTE;
			state        <= SPW_ST_RUN;
			mode         <= SPW_IDLE;
			wcnt         <= '0;
			clk_en_o     <= '1;
			periph_clk_o <= '1;
			periph_acc_o <= '1;
			port_in_o    <= '0;
			clamp_q      <= 1'b0;
			pin_irq_o    <= 2'b00;
			irq_o        <= 1'b0;
		end else begin
			sleep_ctrl   <= next_sleep_ctrl;
			clk_stop     <= next_clk_stop;
			pin_en       <= next_pin_en;
			pin_sense    <= next_pin_sense;
			tmr_cfg      <= next_tmr_cfg;
			irq_stat     <= next_irq_stat;
			irq_mask     <= next_irq_mask;
			rdata_o      <= next_rdata;
			state        <= next_state;
			mode         <= next_mode;
			wcnt         <= next_wcnt;
			clk_en_o     <= next_clk_en;
			periph_clk_o <= next_periph_clk;
			periph_acc_o <= next_periph_acc;
			port_in_o    <= next_port_in;
			clamp_q      <= next_clamp_q;
			pin_irq_o    <= next_pin_irq;
			irq_o        <= next_irq;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_standby_wake;
		state == SPW_ST_SLEEP && mode == SPW_STANDBY && wake_ok;
	endsequence

	property p_standby_six;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_standby_wake |=> (state == SPW_ST_WAKE)[*6] ##1 state == SPW_ST_RUN;
	endproperty
	a_standby_six: assert property (p_standby_six) else $error("standby wake not six cycles");

	property p_clamp_deep;
		@(posedge ref_clk_i) disable iff (rst_i)
		clamp |=> port_in_o == '0;
	endproperty
	a_clamp_deep: assert property (p_clamp_deep) else $error("inputs not clamped");

	property p_pdown_no_edge;
		@(posedge ref_clk_i) disable iff (rst_i)
		(state == SPW_ST_SLEEP && mode == SPW_PDOWN && !(|wake_i) && !(|(ext_lvl & ext_req))) |=> state == SPW_ST_SLEEP;
	endproperty
	a_pdown_no_edge: assert property (p_pdown_no_edge) else $error("illegal wake from power-down");

	property p_stop_gates;
		@(posedge ref_clk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == ADDR_CLK_STOP && bus_i.wdata[0]) |=> ##1 !periph_clk_o[0];
	endproperty
	a_stop_gates: assert property (p_stop_gates) else $error("stopped clock still running");

	property p_restart;
		@(posedge ref_clk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == ADDR_CLK_STOP && !bus_i.wdata[0] && next_clk_en.io) |=> ##1 periph_clk_o[0] || !clk_en_o.io;
	endproperty
	a_restart: assert property (p_restart) else $error("clock not restarted");

	property p_en_reads_zero;
		@(posedge ref_clk_i) disable iff (rst_i)
		(bus_i.rd && bus_i.addr == ADDR_PIN_EN) |=> rdata_o[7:2] == 6'b00_0000;
	endproperty
	a_en_reads_zero: assert property (p_en_reads_zero) else $error("reserved bits nonzero");

	property p_gie_gate;
		@(posedge ref_clk_i) disable iff (rst_i)
		!global_ie_i |=> pin_irq_o == 2'b00;
	endproperty
	a_gie_gate: assert property (p_gie_gate) else $error("pin irq without global enable");

	property p_idle_cpu_off;
		@(posedge ref_clk_i) disable iff (rst_i)
		(state == SPW_ST_SLEEP && mode == SPW_IDLE) |-> !clk_en_o.cpu && clk_en_o.io && clk_en_o.main_osc;
	endproperty
	a_idle_cpu_off: assert property (p_idle_cpu_off) else $error("idle clock set wrong");

	property p_sleep_enter;
		@(posedge ref_clk_i) disable iff (rst_i)
		(state == SPW_ST_RUN && sleep_i && sleep_ctrl[POS_SLEEP_EN]) |=> state == SPW_ST_SLEEP ##1 !clk_en_o.cpu || state != SPW_ST_SLEEP;
	endproperty
	a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

	property p_clamp_release_flag;
		@(posedge ref_clk_i) disable iff (rst_i)
		(clamp_q && !clamp && ext_pin_i[0] && !pin_en[0] && pin_sense[1:0] == SENSE_RISE) |=> irq_stat[IRQ_PIN0];
	endproperty
	a_clamp_release_flag: assert property (p_clamp_release_flag) else $error("release edge lost");

	property p_clamp_release_flag1;
		@(posedge ref_clk_i) disable iff (rst_i)
		(clamp_q && !clamp && ext_pin_i[1] && !pin_en[1] && pin_sense[3:2] == SENSE_RISE) |=> irq_stat[IRQ_PIN1];
	endproperty
	a_clamp_release_flag1: assert property (p_clamp_release_flag1) else $error("pin one release edge lost");

endmodule : spw_ctrl

/* File: tb/spw_far_end.sv */
// Behavioural model of the core and pin side of the sleep controller
`timescale 1ns/1ps
module spw_far_end
	import spw_pkg::*;
(
	input  wire logic          ref_clk_i, // Clock
	output logic               sleep_o,   // Sleep instruction pulse
	output logic               gie_o,     // Core global enable
	output spw_pkg::spw_wake_t wake_o,    // Wake events
	output logic [1:0]         pin_o      // External interrupt pins
);
	initial begin
		sleep_o = 1'b0;
		gie_o   = 1'b1;
		wake_o  = '0;
		pin_o   = 2'h0;
	end

	// Sources pulse for one cycle only, so a missed event stays missed
	task automatic pulse(input logic s, input logic [7:0] w);
		@(posedge ref_clk_i);
		sleep_o <= s;
		wake_o  <= w;
		@(posedge ref_clk_i);
		sleep_o <= 1'b0;
		wake_o  <= '0;
	endtask : pulse

	task automatic drive(input logic g, input logic [1:0] p);
		@(posedge ref_clk_i);
		gie_o <= g;
		pin_o <= p;
	endtask : drive
endmodule : spw_far_end

/* File: tb/tb.sv */
// Self-checking bench for the sleep, power reduction and wake controller
`timescale 1ns/1ps
module tb;
	import spw_pkg::*;
	logic       ref_clk_i;
	logic       rst_i;
	spw_bus_t   bus;
	spw_wake_t  wake;
	spw_clk_t   clk_en;
	logic       sleep;
	logic       gie;
	logic       irq;
	logic       rd_q;
	logic [1:0] pin;
	logic [1:0] pin_irq;
	logic [7:0] rdata;
	logic [7:0] port_pin;
	logic [7:0] port_q;
	logic [7:0] port_in;
	logic [7:0] periph_clk;
	logic [7:0] periph_acc;
	logic [7:0] r;
	logic [7:0] exp_q[$];
	int         n_errors;
	int         total_checks;
	int         cycles;
	int         seed;
	// ----
	// Sleep table: mode, wake event, clocks while asleep
	// ----
	spw_mode_t  t_mode[10] = '{SPW_IDLE, SPW_ADC_NR, SPW_ADC_NR, SPW_PDOWN, SPW_PDOWN,
		SPW_PSAVE, SPW_PSAVE, SPW_PDOWN, SPW_STANDBY, SPW_STANDBY};
	logic [7:0] t_src[10]  = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h80, 8'h02, 8'h01, 8'h02, 8'h20, 8'h10};
	logic [6:0] t_clk[10]  = '{7'h1F, 7'h0F, 7'h0F, 7'h00, 7'h00, 7'h05, 7'h05, 7'h00, 7'h02, 7'h00};
	logic [9:0] t_wake     = 10'h135;
	logic [9:0] t_xtal     = 10'h100;
	logic [1:0] s_code[3]  = '{2'h3, 2'h2, 2'h1};
	logic [2:0] s_pre      = 3'h2;

	spw_far_end u_far (.ref_clk_i(ref_clk_i), .sleep_o(sleep), .gie_o(gie), .wake_o(wake), .pin_o(pin));

	spw_ctrl u_dut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata), .sleep_i(sleep),
		.global_ie_i(gie), .wake_i(wake), .ext_pin_i(pin), .port_pin_i(port_pin), .clk_en_o(clk_en),
		.periph_clk_o(periph_clk), .periph_acc_o(periph_acc), .port_in_o(port_in),
		.pin_irq_o(pin_irq), .irq_o(irq)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		if (n_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk_i);
		bus.wr <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge ref_clk_i);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk_i);
		bus.rd <= 1'b0;
	endtask : bus_rd

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : tick

	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	// Read data stand only in the cycle after the strobe
	always @(posedge ref_clk_i) begin
		rd_q     <= bus.rd;
		port_q   <= port_pin;
		port_pin <= 8'($random(seed));
		cycles++;
		if (rd_q && exp_q.size() > 0)
			check(rdata, exp_q.pop_front());
		if (cycles > 20000) begin
			n_errors++;
			report_and_stop();
		end
	end

	initial begin
		seed     = 11;
		n_errors = 0;
		total_checks = 0;
		bus      = '0;
		rst_i    = 1'b1;
		repeat (3) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		tick(1);
		check({1'b0, clk_en}, 8'h7F);
		bus_rd(ADDR_PIN_EN, 8'h00);
		bus_wr(ADDR_PIN_EN, 8'hFF);
		bus_rd(ADDR_PIN_EN, 8'h03);
		bus_rd(4'hC, 8'h00);
		bus_wr(ADDR_PIN_EN, 8'h00);
		// Software has already quiesced the peripherals it stops
		r = 8'($random(seed));
		bus_wr(ADDR_CLK_STOP, r);
		tick(2);
		check(periph_clk, ~r);
		check(periph_acc, ~r);
		bus_rd(ADDR_CLK_STOP, r);
		bus_wr(ADDR_CLK_STOP, 8'h00);
		tick(2);
		check(periph_clk, 8'hFF);
		check(periph_acc, 8'hFF);
		// Async timer running with overflow wake only
		bus_wr(ADDR_TMR_CFG, 8'h0B);
		for (int i = 0; i < 10; i++) begin
			bus_wr(ADDR_SLEEP_CTRL, {3'h0, t_xtal[i], 1'b1, t_mode[i]});
			u_far.pulse(1'b1, 8'h00);
			tick(2);
			check({1'b0, clk_en}, {1'b0, t_clk[i]});
			check(port_in, (t_mode[i] > SPW_ADC_NR) ? 8'h00 : port_q);
			// Mode 110 without crystal settles as power-down
			bus_rd(ADDR_STATE, {1'b0, (t_xtal[i] || t_mode[i] != SPW_STANDBY) ? t_mode[i] : SPW_PDOWN, 4'h1});
			u_far.pulse(1'b0, t_src[i]);
			tick(3);
			check({7'h00, clk_en.cpu}, {7'h00, t_wake[i] & !t_xtal[i]});
			u_far.pulse(1'b0, 8'h40);
			tick(10);
			check({1'b0, clk_en}, 8'h7F);
		end
		// Timer on the main clock: its oscillator stays off in idle and power-save
		bus_wr(ADDR_TMR_CFG, 8'h05);
		for (int m = 0; m < 2; m++) begin
			bus_wr(ADDR_SLEEP_CTRL, {5'h01, m ? SPW_PSAVE : SPW_IDLE});
			u_far.pulse(1'b1, 8'h00);
			tick(2);
			check({1'b0, clk_en}, m ? 8'h06 : 8'h1E);
			u_far.pulse(1'b0, 8'h40);
			tick(2);
			check({1'b0, clk_en}, 8'h7F);
		end
		// Pin zero enabled on falling edge, pin one rising but disabled
		bus_wr(ADDR_PIN_EN, 8'h01);
		bus_wr(ADDR_PIN_SENSE, 8'h0E);
		u_far.drive(1'b1, 2'h3);
		bus_wr(ADDR_IRQ_STAT, 8'h07);
		bus_wr(ADDR_SLEEP_CTRL, {5'h01, SPW_PDOWN});
		u_far.pulse(1'b1, 8'h00);
		u_far.drive(1'b1, 2'h2);
		tick(3);
		check({7'h00, clk_en.cpu}, 8'h00);
		bus_wr(ADDR_PIN_SENSE, 8'h0C);
		tick(3);
		check({7'h00, clk_en.cpu}, 8'h01);
		bus_rd(ADDR_IRQ_STAT, 8'h05);
		// Every edge code sets the sticky flag in active mode
		bus_wr(ADDR_IRQ_MASK, 8'h02);
		for (int k = 0; k < 3; k++) begin
			u_far.drive(1'b1, {1'b1, s_pre[k]});
			bus_wr(ADDR_PIN_SENSE, {4'h0, 2'h3, s_code[k]});
			bus_wr(ADDR_IRQ_STAT, 8'h07);
			u_far.drive(1'b1, {1'b1, !s_pre[k]});
			tick(3);
			check({7'h00, irq}, 8'h01);
			bus_rd(ADDR_IRQ_STAT, 8'h02);
		end
		bus_wr(ADDR_IRQ_MASK, 8'h00);
		tick(2);
		check({7'h00, irq}, 8'h00);
		bus_wr(ADDR_IRQ_MASK, 8'h02);
		bus_wr(ADDR_IRQ_STAT, 8'h02);
		tick(2);
		check({7'h00, irq}, 8'h00);
		bus_rd(ADDR_IRQ_STAT, 8'h00);
		// Level request needs both enables
		bus_wr(ADDR_PIN_SENSE, 8'h0C);
		u_far.drive(1'b1, 2'h2);
		tick(3);
		check({6'h00, pin_irq}, 8'h01);
		u_far.drive(1'b0, 2'h2);
		tick(3);
		check({6'h00, pin_irq}, 8'h00);
		tick(3);
		report_and_stop();
	end
endmodule : tb
